// File: src/tsc_capture.sv
// twelve gpio time stamp capture units with cascading and read release
`timescale 1ns/100ps
`include "tsc_params.svh"
module tsc_capture #(
  parameter int DEPTH_STD = `TSC_DEPTH_STD,
  parameter int DEPTH_DEEP = `TSC_DEPTH_DEEP,
  parameter int DEEP_UNIT = `TSC_DEEP_UNIT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`TSC_PINS-1:0] gpio_in,
  input wire logic [`TSC_SEC_W-1:0] ptp_seconds,
  input wire logic [`TSC_NS_W-1:0] ptp_nanoseconds,
  input wire logic [`TSC_SUBNS_W-1:0] ptp_subns,
  input wire logic [`TSC_UNITS*`TSC_CFG_W-1:0] capture_unit_config,
  input wire logic [`TSC_UNITS-1:0] capture_unit_enable_bits,
  input wire logic [`TSC_UNITS-1:0] capture_irq_enable_bits,
  input wire logic [`TSC_UNITS-1:0] status_clear,
  input wire logic read_strobe,
  input wire logic [`TSC_PIN_W-1:0] read_unit,
  input wire logic [`TSC_SLOT_W-1:0] read_slot,
  input wire logic release_strobe,
  output logic [`TSC_HALF_W-1:0] sample_seconds_high,
  output logic [`TSC_HALF_W-1:0] sample_seconds_low,
  output logic [`TSC_HALF_W-1:0] sample_nanoseconds_high,
  output logic [`TSC_HALF_W-1:0] sample_nanoseconds_low,
  output logic [`TSC_SUBNS_W-1:0] sample_subns_code,
  output logic read_valid,
  output logic [`TSC_UNITS*`TSC_CNT_W-1:0] sample_count,
  output logic [`TSC_UNITS-1:0] unit_full,
  output logic [`TSC_UNITS-1:0] event_status
);

  // pin synchroniser, first stage read only by the second
  logic [`TSC_PINS-1:0] pin_meta_reg;
  logic [`TSC_PINS-1:0] pin_sync_reg;
  logic [`TSC_PINS-1:0] pin_last_reg;

  // per-unit bookkeeping
  logic [`TSC_CNT_W-1:0] count_reg [`TSC_UNITS];
  tsc_pkg::tsc_sample_t smp_reg [`TSC_UNITS][DEPTH_DEEP];
  logic [`TSC_UNITS-1:0] status_reg;
  logic [`TSC_UNITS-1:0] full;
  logic [`TSC_UNITS-1:0] hit;
  logic [`TSC_UNITS-1:0] take;
  logic [`TSC_UNITS-1:0] chain_hold;
  tsc_pkg::tsc_sample_t now_sample;

  // two-flop sync then one more stage for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_last_reg <= '0;
    end else begin
      pin_meta_reg <= gpio_in;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  // current precision time, sub-ns code held to its legal range
  always_comb begin
    now_sample.seconds = ptp_seconds;
    now_sample.nanoseconds = ptp_nanoseconds;
    now_sample.subns = (ptp_subns > `TSC_SUBNS_MAX) ?
                       `TSC_SUBNS_MAX : ptp_subns;
  end

  // edge detection and capacity per unit
  always_comb begin
    logic [`TSC_PIN_W-1:0] pin;
    logic now_lvl;
    logic was_lvl;
    logic [`TSC_CFG_W-1:0] cfg;
    pin = '0;
    now_lvl = 1'b0;
    was_lvl = 1'b0;
    cfg = '0;
    for (int u = 0; u < `TSC_UNITS; u++) begin
      cfg = capture_unit_config[u*`TSC_CFG_W +: `TSC_CFG_W];
      pin = cfg[`TSC_CFG_PIN_LO +: `TSC_PIN_W];
      now_lvl = pin_sync_reg[pin];
      was_lvl = pin_last_reg[pin];
      // (pulse = both bits, either edge counts)
      hit[u] = capture_unit_enable_bits[u] & (
               (cfg[`TSC_CFG_RISE] & now_lvl & ~was_lvl) |
               (cfg[`TSC_CFG_FALL] & ~now_lvl & was_lvl));
      full[u] = (u == DEEP_UNIT) ?
                (count_reg[u] >= `TSC_CNT_W'(DEPTH_DEEP)) :
                (count_reg[u] >= `TSC_CNT_W'(DEPTH_STD));
    end
  end

  // cascade: a unit whose enabled predecessor chains into it only takes the
  // event once that predecessor is full; order wraps from the deep unit
  always_comb begin
    for (int u = 0; u < `TSC_UNITS; u++) begin
      chain_hold[u] = capture_unit_config[u*`TSC_CFG_W + `TSC_CFG_CHAIN] &
                      capture_unit_enable_bits[u] & ~full[u];
    end
  end

  // a unit with room takes an edge unless its enabled chaining predecessor has room left
  always_comb begin
    int p;
    p = 0;
    for (int u = 0; u < `TSC_UNITS; u++) begin
      p = (u == 0) ? `TSC_UNITS - 1 : u - 1;
      take[u] = hit[u] & ~full[u] & ~chain_hold[p];
    end
  end

  // fill counters; release restarts at sample one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int u = 0; u < `TSC_UNITS; u++) begin
        count_reg[u] <= '0;
      end
    end else begin
      for (int u = 0; u < `TSC_UNITS; u++) begin
        if (release_strobe && read_unit == u[`TSC_PIN_W-1:0]) begin
          count_reg[u] <= '0;
        end else if (take[u]) begin
          count_reg[u] <= count_reg[u] + 4'h1;
        end
      end
    end
  end

  // sample storage, written at the slot the counter points to
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int u = 0; u < `TSC_UNITS; u++) begin
        for (int s = 0; s < DEPTH_DEEP; s++) begin
          smp_reg[u][s] <= '0;
        end
      end
    end else begin
      for (int u = 0; u < `TSC_UNITS; u++) begin
        if (take[u]) begin
          smp_reg[u][count_reg[u][`TSC_SLOT_W-1:0]] <= now_sample;
        end
      end
    end
  end

  // event status: set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~status_clear) |
                    (take & capture_irq_enable_bits);
    end
  end

  // read port, one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_seconds_high <= '0;
      sample_seconds_low <= '0;
      sample_nanoseconds_high <= '0;
      sample_nanoseconds_low <= '0;
      sample_subns_code <= '0;
      read_valid <= 1'b0;
    end else begin
      read_valid <= read_strobe;
      if (read_strobe) begin
        if (read_unit < `TSC_UNITS) begin
          // (split into high and low halves)
          sample_seconds_high <= smp_reg[read_unit][read_slot].seconds[
            `TSC_SEC_W-1 -: `TSC_HALF_W];
          sample_seconds_low <= smp_reg[read_unit][read_slot].seconds[
            `TSC_HALF_W-1:0];
          sample_nanoseconds_high <=
            smp_reg[read_unit][read_slot].nanoseconds[
            `TSC_NS_W-1 -: `TSC_HALF_W];
          sample_nanoseconds_low <=
            smp_reg[read_unit][read_slot].nanoseconds[`TSC_HALF_W-1:0];
          sample_subns_code <= smp_reg[read_unit][read_slot].subns;
        end else begin
          sample_seconds_high <= '0;
          sample_seconds_low <= '0;
          sample_nanoseconds_high <= '0;
          sample_nanoseconds_low <= '0;
          sample_subns_code <= '0;
        end
      end
    end
  end

  // status outputs, all from registers
  always_comb begin
    for (int u = 0; u < `TSC_UNITS; u++) begin
      sample_count[u*`TSC_CNT_W +: `TSC_CNT_W] = count_reg[u];
    end
  end
  assign unit_full = full;
  assign event_status = status_reg;

endmodule

// File: src/tsc_params.svh
// constants for the gpio time stamp capture block
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH
`define TSC_UNITS 12
`define TSC_DEEP_UNIT 11
`define TSC_DEPTH_STD 4'h2
`define TSC_DEPTH_DEEP 4'h8
`define TSC_SLOT_W 3
`define TSC_CNT_W 4
`define TSC_CFG_W 16
`define TSC_PIN_W 4
`define TSC_PINS 16
`define TSC_CFG_CHAIN 0
`define TSC_CFG_FALL 6
`define TSC_CFG_RISE 7
`define TSC_CFG_PIN_LO 8
`define TSC_SEC_W 32
`define TSC_NS_W 32
`define TSC_HALF_W 16
`define TSC_SUBNS_W 3
`define TSC_SUBNS_MAX 3'h4
`define TSC_SUBNS_STEP_NS 8
`define TSC_CLK_MHZ 125
`define TSC_REF_MHZ 25
`endif

// File: src/tsc_pkg.sv
// types for the gpio time stamp capture block
`include "tsc_params.svh"
package tsc_pkg;
  // one captured time stamp
  typedef struct packed {
    logic [`TSC_SEC_W-1:0] seconds;
    logic [`TSC_NS_W-1:0] nanoseconds;
    logic [`TSC_SUBNS_W-1:0] subns;
  } tsc_sample_t;
endpackage

// File: testbench/tsc_pin_model.sv
// model of the external signals on the general-purpose pins
`timescale 1ns/100ps
module tsc_pin_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] flip,
  output logic [15:0] pins
);
  // each flip bit toggles its pin at the next edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins <= 16'h0000;
    end else begin
      pins <= pins ^ flip;
    end
  end
endmodule

// File: testbench/tsc_capture_assertions.sv
// port assertions for the capture block
`timescale 1ns/100ps
module tsc_capture_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] capture_unit_enable_bits,
  input wire logic [11:0] capture_irq_enable_bits,
  input wire logic read_strobe,
  input wire logic [3:0] read_unit,
  input wire logic release_strobe,
  input wire logic [2:0] sample_subns_code,
  input wire logic read_valid,
  input wire logic [47:0] sample_count,
  input wire logic [11:0] unit_full,
  input wire logic [11:0] event_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // read answer, fill counts, release and status
  AST_RV: assert property (read_valid == $past(read_strobe))
    else $error("read valid late");
  AST_SUB: assert property (sample_subns_code <= 3'h4)
    else $error("subns code above four");
  AST_FULL0: assert property (
    unit_full[0] == (sample_count[3:0] >= 4'h2))
    else $error("unit 0 full flag wrong");
  AST_FULL11: assert property (
    unit_full[11] == (sample_count[47:44] >= 4'h8))
    else $error("deep unit full flag wrong");
  AST_CAP0: assert property (sample_count[3:0] <= 4'h2)
    else $error("unit 0 over two samples");
  AST_REL: assert property (release_strobe && read_unit == 4'h0 |=>
    sample_count[3:0] == 4'h0) else $error("release ignored");
  AST_OFF: assert property (
    !capture_unit_enable_bits[1] && !release_strobe |=>
    $stable(sample_count[7:4])) else $error("disabled unit took");
  AST_IRQ: assert property ($rose(event_status[0]) |->
    $past(capture_irq_enable_bits[0])) else $error("status without enable");
  AST_STEP: assert property (sample_count[47:44] <=
    $past(sample_count[47:44]) + 4'h1) else $error("deep count jumped");
endmodule

// File: testbench/tsc_capture_bench.sv
// self-checking bench for the capture block
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", n, e, a); end end
module tsc_capture_bench;
  logic clk = 0, rstn = 0, rs = 0, rel = 0;
  logic [15:0] flip = '0, gp, ssh, ssl, snh, snl;
  logic [31:0] sec = '0, ns = '0, es[9], ens[9];
  logic [2:0] sub = '0, rsl = '0, scode, eb[9];
  logic [191:0] cfg = '0;
  logic [11:0] en = '0, ie = '0, clr = '0, full, evs;
  logic [3:0] ru = '0;
  logic [47:0] cnt;
  logic rv;
  int bad_count = 0, samples_checked = 0, p, q, r;
  always #4 clk = ~clk;
  tsc_pin_model i_pins (.clk(clk), .rstn(rstn), .flip(flip), .pins(gp));
  tsc_capture i_dut (.clk(clk), .rstn(rstn), .gpio_in(gp),
    .ptp_seconds(sec), .ptp_nanoseconds(ns), .ptp_subns(sub),
    .capture_unit_config(cfg), .capture_unit_enable_bits(en),
    .capture_irq_enable_bits(ie), .status_clear(clr), .read_strobe(rs),
    .read_unit(ru), .read_slot(rsl), .release_strobe(rel),
    .sample_seconds_high(ssh), .sample_seconds_low(ssl),
    .sample_nanoseconds_high(snh), .sample_nanoseconds_low(snl),
    .sample_subns_code(scode), .read_valid(rv), .sample_count(cnt),
    .unit_full(full), .event_status(evs));
  // stored code saturates at four
  function automatic logic [2:0] clip(input logic [2:0] c);
    return (c > 3'h4) ? 3'h4 : c;
  endfunction
  // event time in ns as software rebuilds it from the code
  function automatic logic [31:0] tn(input logic [31:0] n,
                                     input logic [2:0] c);
    return n + 32'(c) * 32'h8;
  endfunction
  // new random time, then one pin toggle
  task automatic ev(input int pin, input int k);
    @(posedge clk);
    sec <= $urandom;
    ns <= $urandom;
    sub <= 3'($urandom);
    flip <= 16'h0001 << pin;
    @(posedge clk);
    flip <= '0;
    repeat (6) @(posedge clk);
    es[k] = sec;
    ens[k] = ns;
    eb[k] = sub;
  endtask
  // read one slot and compare with capture k
  task automatic rd(input int u, input int s, input int k);
    @(posedge clk);
    rs <= 1'b1;
    ru <= 4'(u);
    rsl <= 3'(s);
    @(posedge clk);
    rs <= 1'b0;
    @(negedge clk);
    `CHK("valid", 1'b1, rv)
    `CHK("sec", es[k], {ssh, ssl})
    `CHK("ns", ens[k], {snh, snl})
    `CHK("subns", clip(eb[k]), scode)
    `CHK("truens", tn(ens[k], clip(eb[k])), tn({snh, snl}, scode))
  endtask
  task automatic close_out;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    close_out;
  end
  // main sequence
  initial begin
    void'($urandom(52));
    p = $urandom_range(15);
    q = (p + 1 + $urandom_range(14)) % 16;
    r = (p + 1) % 16;
    if (r == q) r = (r + 1) % 16;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    cfg[15:0] <= {4'h0, 4'(p), 8'h80};
    cfg[31:16] <= {4'h0, 4'(p), 8'h80};
    cfg[191:176] <= {4'h0, 4'(q), 8'hc0};
    en <= 12'h801;
    ie <= 12'h001;
    for (int k = 0; k < 5; k++) ev(p, k);
    `CHK("count0", 4'h2, cnt[3:0])
    `CHK("count1", 4'h0, cnt[7:4])
    `CHK("status", 12'h001, evs)
    `CHK("full", 12'h001, full)
    rd(0, 0, 0);
    rd(0, 1, 2);
    for (int k = 0; k < 9; k++) ev(q, k);
    `CHK("count11", 4'h8, cnt[47:44])
    `CHK("full11", 12'h801, full)
    `CHK("irqoff", 1'b0, evs[11])
    for (int k = 0; k < 8; k++) rd(11, k, k);
    @(posedge clk);
    clr <= 12'h001;
    rel <= 1'b1;
    ru <= 4'h0;
    @(posedge clk);
    clr <= '0;
    rel <= 1'b0;
    @(negedge clk);
    `CHK("released", 4'h0, cnt[3:0])
    `CHK("cleared", 1'b0, evs[0])
    ev(p, 0);
    ev(p, 1);
    rd(0, 0, 1);
    // cascade: fall-only unit 3 hands over to unit 4 once full
    @(posedge clk);
    cfg[63:48] <= {4'h0, 4'(r), 8'h41};
    cfg[79:64] <= {4'h0, 4'(r), 8'h40};
    en <= 12'h819;
    ie <= 12'h019;
    for (int k = 0; k < 6; k++) ev(r, k);
    `CHK("count3", 4'h2, cnt[15:12])
    `CHK("count4", 4'h1, cnt[19:16])
    `CHK("full2", 12'h808, full)
    `CHK("status2", 12'h019, evs)
    rd(3, 0, 1);
    rd(3, 1, 3);
    rd(4, 0, 5);
    // a unit number past the last one reads as zeros
    @(posedge clk);
    rs <= 1'b1;
    ru <= 4'hc;
    @(posedge clk);
    rs <= 1'b0;
    @(negedge clk);
    `CHK("nounit", 32'h0, {ssh, ssl})
    close_out;
  end
endmodule
bind tsc_capture tsc_capture_checker i_chk (.clk(clk), .rstn(rstn),
  .capture_unit_enable_bits(capture_unit_enable_bits),
  .capture_irq_enable_bits(capture_irq_enable_bits),
  .read_strobe(read_strobe), .read_unit(read_unit),
  .release_strobe(release_strobe), .sample_subns_code(sample_subns_code),
  .read_valid(read_valid), .sample_count(sample_count),
  .unit_full(unit_full), .event_status(event_status));
